/* File: logic/dmr_mode_ctrl.sv */
// Device-side command decode, mode word storage, burst order and recovery
//
// Contract
// - Bank select 2 loads second extended word
// - Bank select 3 loads third extended word
// - Bank select 1 loads first extended word
// - Bank select 0 with A8 resets DLL
// - Every load without the test bit replaces all thirteen bits
// - Mode word holds until next load, except the DLL reset bit
// - Burst size from bits 2:0, four or eight
// - Burst wraps inside aligned column block
// - Bit 3 picks sequential or interleaved order
// - Interleaved beat column is start XOR index
// - Test bit set programs no other field
// - DLL reset bit self-clears after issue
// - Auto precharge waits write recovery clocks
// - Bit 12 picks fast or slow exit
// - Bank lines pick register, address carries data
// - Chip select high masks every command
`timescale 1ns/1ps
`default_nettype none
module dmr_mode_ctrl #(
  parameter int WR_CNT_W = 4
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // Command pins, sampled on the rising edge
  input  wire logic        cke_in,
  input  wire logic        cs_n_in,
  input  wire logic        ras_n_in,
  input  wire logic        cas_n_in,
  input  wire logic        we_n_in,
  input  wire logic [2:0]  bank_in,
  input  wire logic [12:0] addr_in,
  // Burst column generation
  input  wire logic        burst_start_in,
  input  wire logic [2:0]  start_col_in,
  output logic [2:0]       beat_col_out,
  output logic             beat_valid_out,
  // Write with auto precharge
  input  wire logic        write_done_in,
  output logic             auto_pre_out,
  output logic             recovery_busy_out,
  // Mode state
  output logic [12:0]      operating_mode_word_out,
  output logic [12:0]      first_extended_mode_word_out,
  output logic [12:0]      second_extended_mode_word_out,
  output logic [12:0]      third_extended_mode_word_out,
  output logic             test_mode_out,
  output logic             burst_size_8_out,
  output logic             interleaved_out,
  output logic             active_sleep_slow_exit_out,
  output logic             dll_reset_pulse_out,
  output logic             dll_locked_out
);

  typedef enum logic [1:0] {
    DMR_IDLE  = 2'b00,
    DMR_BURST = 2'b01
  } dmr_burst_t;

  logic [12:0] op_q;
  logic [12:0] ext1_q;
  logic [12:0] ext2_q;
  logic [12:0] ext3_q;
  logic        test_q;
  logic        load_cmd;
  logic        dll_rst_q;
  logic [7:0]  lock_cnt_q;
  dmr_burst_t  state_q;
  logic [2:0]  start_q;
  logic [2:0]  beat_q;
  logic [2:0]  beat_last;
  logic [2:0]  col_d;
  logic [WR_CNT_W-1:0] wr_clocks;

  // Load mode decode; chip select high masks the decoder
  assign load_cmd = cke_in && !cs_n_in && !ras_n_in && !cas_n_in && !we_n_in;

  // Main mode word; test mode bit blocks every other field
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      op_q   <= dmr_pkg::MODE_RESET;
      test_q <= 1'b0;
    end else if (load_cmd && bank_in == dmr_pkg::SEL_MAIN) begin
      if (addr_in[dmr_pkg::TEST_MODE_BIT]) begin
        test_q <= 1'b1;
      end else begin
        test_q <= 1'b0;
        op_q   <= addr_in;
      end
    end else if (op_q[dmr_pkg::DLL_RESET_BIT]) begin
      op_q[dmr_pkg::DLL_RESET_BIT] <= 1'b0;
    end
  end

  // Extended words: whole word replaced per load
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ext1_q <= dmr_pkg::MODE_RESET;
      ext2_q <= dmr_pkg::MODE_RESET;
      ext3_q <= dmr_pkg::MODE_RESET;
    end else if (load_cmd) begin
      if (bank_in == dmr_pkg::SEL_FIRST) begin
        ext1_q <= addr_in;
      end
      if (bank_in == dmr_pkg::SEL_SECOND) begin
        ext2_q <= addr_in;
      end
      if (bank_in == dmr_pkg::SEL_THIRD) begin
        ext3_q <= addr_in;
      end
    end
  end

  // DLL reset pulse and lock counter
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      dll_rst_q <= 1'b0;
    end else begin
      dll_rst_q <= load_cmd && bank_in == dmr_pkg::SEL_MAIN
                   && !addr_in[dmr_pkg::TEST_MODE_BIT] && addr_in[dmr_pkg::DLL_RESET_BIT];
    end
  end

  // Lock flag only informs; reads are not blocked, the controller must wait
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      lock_cnt_q <= '0;
    end else if (dll_rst_q) begin
      lock_cnt_q <= 8'(dmr_pkg::DLL_LOCK_CLOCKS);
    end else if (lock_cnt_q != '0) begin
      lock_cnt_q <= lock_cnt_q - 8'h01;
    end
  end

  assign dll_reset_pulse_out = dll_rst_q;
  assign dll_locked_out      = (lock_cnt_q == '0) && !dll_rst_q;

  // Field views
  assign burst_size_8_out = op_q[dmr_pkg::BURST_MSB:dmr_pkg::BURST_LSB]
                            == dmr_pkg::BURST_CODE_8;
  assign interleaved_out  = op_q[dmr_pkg::ORDER_BIT];
  assign active_sleep_slow_exit_out = op_q[dmr_pkg::SLEEP_EXIT_BIT];
  assign test_mode_out    = test_q;

  // Burst sequencer; same length for reads and writes
  assign beat_last = burst_size_8_out ? 3'h7 : 3'h3;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= DMR_IDLE;
      start_q <= '0;
      beat_q  <= '0;
    end else begin
      case (state_q)
        DMR_IDLE: begin
          if (burst_start_in) begin
            state_q <= DMR_BURST;
            start_q <= start_col_in;
            beat_q  <= '0;
          end
        end
        DMR_BURST: begin
          if (beat_q == beat_last) begin
            state_q <= DMR_IDLE;
          end else begin
            beat_q <= beat_q + 3'h1;
          end
        end
        default: state_q <= DMR_IDLE;
      endcase
    end
  end

  // Column order within the aligned block
  always_comb begin
    col_d = '0;
    if (interleaved_out) begin
      col_d = start_q ^ beat_q;
    end else if (burst_size_8_out) begin
      col_d = {start_q[2] ^ beat_q[2], 2'(start_q[1:0] + beat_q[1:0])};
    end else begin
      col_d = {1'b0, 2'(start_q[1:0] + beat_q[1:0])};
    end
    if (!burst_size_8_out) begin
      col_d[2] = start_q[2];
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      beat_col_out   <= '0;
      beat_valid_out <= 1'b0;
    end else begin
      beat_col_out   <= col_d;
      beat_valid_out <= (state_q == DMR_BURST);
    end
  end

  // Recovery clocks = code + 1
  assign wr_clocks = WR_CNT_W'(op_q[dmr_pkg::WR_MSB:dmr_pkg::WR_LSB]) + WR_CNT_W'(1);

  dmr_wr_timer #(
    .CNT_W (WR_CNT_W)
  ) u_wr_timer (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .start_in (write_done_in),
    .count_in (wr_clocks),
    .busy_out (recovery_busy_out),
    .fire_out (auto_pre_out)
  );

  assign operating_mode_word_out       = op_q;
  assign first_extended_mode_word_out  = ext1_q;
  assign second_extended_mode_word_out = ext2_q;
  assign third_extended_mode_word_out  = ext3_q;

  // Checks
  property p_cs_masks;
    @(posedge clk_in) disable iff (reset_in)
      cs_n_in && !op_q[dmr_pkg::DLL_RESET_BIT] |=> $stable(op_q);
  endproperty
  a_cs_masks: assert property (p_cs_masks) else $error("load taken with chip select high");

  property p_cke_gate;
    @(posedge clk_in) disable iff (reset_in)
      !cke_in |=> $stable(ext1_q) && $stable(ext2_q) && $stable(ext3_q);
  endproperty
  a_cke_gate: assert property (p_cke_gate) else $error("load taken with clock enable low");

  property p_main_load;
    @(posedge clk_in) disable iff (reset_in)
      load_cmd && bank_in == 3'h0 && !addr_in[7] |=> op_q[12:9] == $past(addr_in[12:9])
        && op_q[7:0] == $past(addr_in[7:0]);
  endproperty
  a_main_load: assert property (p_main_load) else $error("main word not loaded whole");

  property p_test_blocks;
    @(posedge clk_in) disable iff (reset_in)
      load_cmd && bank_in == 3'h0 && addr_in[7] && !op_q[8] |=> $stable(op_q) && test_q;
  endproperty
  a_test_blocks: assert property (p_test_blocks) else $error("test load changed fields");

  sequence s_dll_set;
    load_cmd && bank_in == 3'h0 && !addr_in[7] && addr_in[8];
  endsequence
  property p_self_clear;
    @(posedge clk_in) disable iff (reset_in)
      s_dll_set ##1 !load_cmd |=> !op_q[8];
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("dll reset bit did not clear");

  property p_second_load;
    @(posedge clk_in) disable iff (reset_in)
      load_cmd && bank_in == 3'h2 |=> ext2_q == $past(addr_in);
  endproperty
  a_second_load: assert property (p_second_load) else $error("second extended word wrong");

  property p_third_load;
    @(posedge clk_in) disable iff (reset_in)
      load_cmd && bank_in == 3'h3 |=> ext3_q == $past(addr_in);
  endproperty
  a_third_load: assert property (p_third_load) else $error("third extended word wrong");

  property p_first_load;
    @(posedge clk_in) disable iff (reset_in)
      load_cmd && bank_in == 3'h1 |=> ext1_q == $past(addr_in);
  endproperty
  a_first_load: assert property (p_first_load) else $error("first extended word wrong");

  property p_interleave;
    @(posedge clk_in) disable iff (reset_in)
      state_q == DMR_BURST && interleaved_out |=> beat_col_out == ($past(start_q) ^ $past(beat_q));
  endproperty
  a_interleave: assert property (p_interleave) else $error("interleaved column wrong");

  property p_block_wrap;
    @(posedge clk_in) disable iff (reset_in)
      state_q == DMR_BURST && !burst_size_8_out |=> beat_col_out[2] == $past(start_q[2]);
  endproperty
  a_block_wrap: assert property (p_block_wrap) else $error("burst left its block");

  property p_burst_len;
    @(posedge clk_in) disable iff (reset_in)
      state_q == DMR_IDLE && burst_start_in && !burst_size_8_out && !load_cmd
        |=> state_q == DMR_BURST [*4] ##1 state_q == DMR_IDLE;
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst of four wrong length");

  property p_seq8;
    @(posedge clk_in) disable iff (reset_in)
      state_q == DMR_BURST && burst_size_8_out && !interleaved_out
        |=> beat_col_out[2] == ($past(start_q[2]) ^ $past(beat_q[2]));
  endproperty
  a_seq8: assert property (p_seq8) else $error("sequential nibble order wrong");

  property p_recovery;
    @(posedge clk_in) disable iff (reset_in)
      write_done_in && op_q[11:9] == 3'h1 && !load_cmd ##1 !write_done_in ##1 !write_done_in
        |=> auto_pre_out;
  endproperty
  a_recovery: assert property (p_recovery) else $error("auto precharge not after recovery");

  property p_exit_style;
    @(posedge clk_in) disable iff (reset_in)
      load_cmd && bank_in == 3'h0 && !addr_in[7]
        |=> active_sleep_slow_exit_out == $past(addr_in[12]);
  endproperty
  a_exit_style: assert property (p_exit_style) else $error("exit style mismatch");

endmodule // dmr_mode_ctrl
`default_nettype wire

/* File: common/dmr_pkg.sv */
// Package with bank select codes, mode word field layout and timing constants
package dmr_pkg;

  // Mode word width and field positions
  localparam int MODE_W          = 13;
  localparam int BURST_LSB       = 0;
  localparam int BURST_MSB       = 2;
  localparam int ORDER_BIT       = 3;
  localparam int LAT_LSB         = 4;
  localparam int LAT_MSB         = 6;
  localparam int TEST_MODE_BIT   = 7;
  localparam int DLL_RESET_BIT   = 8;
  localparam int WR_LSB          = 9;
  localparam int WR_MSB          = 11;
  localparam int SLEEP_EXIT_BIT  = 12;

  // Burst size codes in bits 2:0
  localparam logic [2:0] BURST_CODE_4 = 3'h2;
  localparam logic [2:0] BURST_CODE_8 = 3'h3;

  // Write recovery: code n selects n+1 clocks, codes 1..7 legal
  localparam logic [2:0] WR_CODE_MIN = 3'h1;
  localparam logic [2:0] WR_CODE_MAX = 3'h7;

  // Bank address selection of the four mode registers
  localparam logic [2:0] SEL_MAIN   = 3'h0;
  localparam logic [2:0] SEL_FIRST  = 3'h1;
  localparam logic [2:0] SEL_SECOND = 3'h2;
  localparam logic [2:0] SEL_THIRD  = 3'h3;

  // Reset values (mode word undefined until loaded; use zero)
  localparam logic [12:0] MODE_RESET = 13'h0000;

  // DLL lock time in clocks after a DLL reset
  localparam int DLL_LOCK_CLOCKS = 200;

  // Column offset width within the largest burst
  localparam int COL_W = 3;

endpackage : dmr_pkg

/* File: logic/dmr_wr_timer.sv */
// Write-recovery countdown that delays internal auto precharge
`timescale 1ns/1ps
`default_nettype none
module dmr_wr_timer #(
  parameter int CNT_W = 4
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  // Control
  input  wire logic             start_in,
  input  wire logic [CNT_W-1:0] count_in,
  // Status
  output logic                  busy_out,
  output logic                  fire_out
);

  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_q <= '0;
    end else if (start_in) begin
      cnt_q <= count_in;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      fire_out <= 1'b0;
    end else begin
      fire_out <= (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1}) && !start_in;
    end
  end

  assign busy_out = (cnt_q != '0);

endmodule // dmr_wr_timer
`default_nettype wire

/* File: dv/dmr_ctrl_model.sv */
// Memory controller model that drives the command and address pins
`timescale 1ns/1ps
`default_nettype none
module dmr_ctrl_model (
  // Clock
  input  wire logic   clk_in,
  // Command and address pins
  output logic        cke_out,
  output logic        cs_n_out,
  output logic        ras_n_out,
  output logic        cas_n_out,
  output logic        we_n_out,
  output logic [2:0]  bank_out,
  output logic [12:0] addr_out
);
  localparam logic [3:0] LOAD = 4'h0;
  localparam logic [3:0] NOP  = 4'h7;
  initial begin
    cke_out = 1'b0;
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hf;
    bank_out = 3'h0;
    addr_out = 13'h0000;
  end
  // One command for one rising edge, then a NOP with the bus inverted,
  // so the device cannot lean on a stale address
  task automatic issue(input logic [3:0] c, input logic [2:0] ba,
                       input logic [12:0] a, input logic ck);
    @(negedge clk_in);
    cke_out = ck;
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} = c;
    bank_out = ba;
    addr_out = a;
    @(negedge clk_in);
    cke_out = 1'b1;
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} = NOP;
    bank_out = ~ba;
    addr_out = ~a;
  endtask
  task automatic load(input logic [2:0] ba, input logic [12:0] a);
    issue(LOAD, ba, a, 1'b1);
  endtask
  task automatic pre_all;
    issue(4'h2, 3'h0, 13'h0400, 1'b1);
  endtask
  task automatic refresh;
    issue(4'h1, 3'h0, 13'h0000, 1'b1);
  endtask
  // Deselect with clock enable high, then the extra wait, then precharge
  task automatic power_up(input int idle);
    @(negedge clk_in);
    cke_out = 1'b1;
    repeat (idle) @(negedge clk_in);
    repeat (80) @(negedge clk_in);
    pre_all();
  endtask
endmodule // dmr_ctrl_model
`default_nettype wire

/* File: dv/tb_top.sv */
// Testbench for the mode register and initialization block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module tb_top;
  logic        clk_in, reset_in, cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in;
  logic        burst_start_in, write_done_in, beat_valid_out, auto_pre_out;
  logic        recovery_busy_out, test_mode_out, burst_size_8_out, interleaved_out;
  logic        active_sleep_slow_exit_out, dll_reset_pulse_out, dll_locked_out;
  logic [2:0]  bank_in, start_col_in, beat_col_out;
  logic [12:0] addr_in, operating_mode_word_out, first_extended_mode_word_out;
  logic [12:0] second_extended_mode_word_out, third_extended_mode_word_out;
  int          err_count = 0;
  int          total_checks = 0;

  dmr_mode_ctrl dut (.clk_in, .reset_in, .cke_in, .cs_n_in, .ras_n_in, .cas_n_in,
    .we_n_in, .bank_in, .addr_in, .burst_start_in, .start_col_in, .beat_col_out,
    .beat_valid_out, .write_done_in, .auto_pre_out, .recovery_busy_out,
    .operating_mode_word_out, .first_extended_mode_word_out,
    .second_extended_mode_word_out, .third_extended_mode_word_out, .test_mode_out,
    .burst_size_8_out, .interleaved_out, .active_sleep_slow_exit_out,
    .dll_reset_pulse_out, .dll_locked_out);
  dmr_ctrl_model ctrl (.clk_in, .cke_out(cke_in), .cs_n_out(cs_n_in),
    .ras_n_out(ras_n_in), .cas_n_out(cas_n_in), .we_n_out(we_n_in),
    .bank_out(bank_in), .addr_out(addr_in));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  task automatic tally_and_finish;
    if (err_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic t_init;
    int n;
    ctrl.power_up(40000);
    ctrl.load(dmr_pkg::SEL_SECOND, 13'h0a5a);
    `CHK("second word", 13'h0a5a, second_extended_mode_word_out)
    ctrl.load(dmr_pkg::SEL_THIRD, 13'h1234);
    `CHK("third word", 13'h1234, third_extended_mode_word_out)
    ctrl.load(dmr_pkg::SEL_FIRST, 13'h0000);
    `CHK("first word", 13'h0000, first_extended_mode_word_out)
    ctrl.load(dmr_pkg::SEL_MAIN, 13'h0100);
    `CHK("dll pulse", 1'b1, dll_reset_pulse_out)
    `CHK("dll locked", 1'b0, dll_locked_out)
    n = 1;
    @(negedge clk_in);
    `CHK("main word", 13'h0000, operating_mode_word_out)
    while (dll_locked_out !== 1'b1 && n < 300) begin
      n++;
      @(negedge clk_in);
    end
    `CHK("lock clocks", dmr_pkg::DLL_LOCK_CLOCKS + 1, n)
    ctrl.pre_all();
    ctrl.refresh();
    ctrl.refresh();
    ctrl.load(dmr_pkg::SEL_MAIN, 13'h143b);
    `CHK("main word", 13'h143b, operating_mode_word_out)
    `CHK("size 8", 1'b1, burst_size_8_out)
    `CHK("interleaved", 1'b1, interleaved_out)
    `CHK("slow exit", 1'b1, active_sleep_slow_exit_out)
    ctrl.load(dmr_pkg::SEL_FIRST, 13'h0380);
    `CHK("first word", 13'h0380, first_extended_mode_word_out)
    ctrl.load(dmr_pkg::SEL_FIRST, 13'h0000);
    `CHK("first word", 13'h0000, first_extended_mode_word_out)
    `CHK("main kept", 13'h143b, operating_mode_word_out)
  endtask

  // Deselected and clock-disabled loads must leave the word alone
  task automatic t_mask;
    ctrl.issue(4'h8, dmr_pkg::SEL_MAIN, 13'h0002, 1'b1);
    `CHK("masked cs", 13'h143b, operating_mode_word_out)
    ctrl.issue(4'h0, dmr_pkg::SEL_MAIN, 13'h0002, 1'b0);
    `CHK("masked cke", 13'h143b, operating_mode_word_out)
  endtask

  task automatic t_test;
    ctrl.load(dmr_pkg::SEL_MAIN, 13'h0083);
    `CHK("test kept", 13'h143b, operating_mode_word_out)
    `CHK("test mode", 1'b1, test_mode_out)
    ctrl.load(dmr_pkg::SEL_MAIN, 13'h1032);
    `CHK("main word", 13'h1032, operating_mode_word_out)
    `CHK("test mode", 1'b0, test_mode_out)
    `CHK("size 8", 1'b0, burst_size_8_out)
  endtask

  task automatic t_burst;
    logic [2:0] e;
    int n;
    for (int m = 0; m < 4; m++) begin
      ctrl.load(dmr_pkg::SEL_MAIN, {9'h003, m[1], 2'b01, m[0]});
      for (int s = 0; s < 8; s++) begin
        @(negedge clk_in);
        burst_start_in = 1'b1;
        start_col_in = s[2:0];
        @(negedge clk_in);
        burst_start_in = 1'b0;
        n = 0;
        while (beat_valid_out !== 1'b1 && n < 8) begin
          n++;
          @(negedge clk_in);
        end
        for (int i = 0; i < (m[0] ? 8 : 4); i++) begin
          e = m[1] ? s[2:0] ^ i[2:0] : {s[2] ^ i[2], s[1:0] + i[1:0]};
          `CHK("beat col", e, beat_col_out)
          `CHK("beat valid", 1'b1, beat_valid_out)
          @(negedge clk_in);
        end
        `CHK("burst end", 1'b0, beat_valid_out)
      end
    end
  endtask

  // Every legal recovery code, counted from the last write data
  task automatic t_recov;
    int n;
    for (int c = 1; c < 8; c++) begin
      ctrl.load(dmr_pkg::SEL_MAIN, {1'b0, c[2:0], 9'h032});
      write_done_in = 1'b1;
      n = 0;
      do begin
        @(negedge clk_in);
        write_done_in = 1'b0;
        n++;
        if (n == 1) `CHK("recovery busy", 1'b1, recovery_busy_out)
      end while (auto_pre_out !== 1'b1 && n < 20);
      // Code c means c+1 clocks; n is already 1 just after the taking edge
      `CHK("recovery", c + 2, n)
      `CHK("recovery done", 1'b0, recovery_busy_out)
      @(negedge clk_in);
      `CHK("pre pulse", 1'b0, auto_pre_out)
    end
  endtask

  initial begin
    reset_in = 1'b1;
    burst_start_in = 1'b0;
    start_col_in = 3'h0;
    write_done_in = 1'b0;
    repeat (3) @(negedge clk_in);
    reset_in = 1'b0;
    t_init();
    t_mask();
    t_test();
    t_burst();
    t_recov();
    tally_and_finish();
  end

  // Run needs about 41000 clocks; allow about twice that
  initial begin
    #400000;
    err_count++;
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
